// ### design/ccr_coord_reg.sv
// One stored characteristic coordinate with clear, load and unused gating
`timescale 1ns/100ps
`include "ccr_map.svh"

module ccr_coord_reg
(
  input logic clk, // System clock
  input logic rst, // Synchronous reset, active high
  input logic clear, // Software reset pulse
  input logic load, // Commit pulse
  input logic [`CCR_COORD_W-1:0] load_val, // Value to commit
  input logic enable, // Coordinate in use
  output logic [`CCR_COORD_W-1:0] value // Value seen by readback
);
  import ccr_pkg::*;

  logic [`CCR_COORD_W-1:0] coord_ff;

  // Clear wins over load so a reset in the commit cycle still leaves zero
  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      coord_ff <= `CCR_RESET_COORD;
    end
    else if (load)
    begin
      coord_ff <= load_val;
    end
  end

  // An unused coordinate reads as zero whatever is stored
  assign value = enable ? coord_ff : `CCR_RESET_COORD;

endmodule // ccr_coord_reg

// ### design/ccr_readback_top.sv
// Blue and alternate color characteristic readback registers behind a Wishbone slave
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "ccr_map.svh"

module ccr_readback_top
(
  input logic MCLK, // 50 MHz system clock
  input logic RESET, // Synchronous reset, active high
  input ccr_pkg::ccr_wb_req_type WB_REQ, // Wishbone request
  output ccr_pkg::ccr_wb_rsp_type WB_RSP, // Wishbone answer
  input logic SW_RESET_CMD, // Software reset pulse from the command decoder
  input ccr_pkg::ccr_power_type POWER_STATE, // Current display power state
  output ccr_pkg::ccr_coord_type BLUE_COORD, // Stored blue coordinates
  output ccr_pkg::ccr_coord_type ALT_COORD, // Stored alternate coordinates, zero if unused
  output logic ALT_USED // Alternate color in use
);
  import ccr_pkg::*;

  // True for the five read-only characteristic codes
  function automatic logic is_char_idx(input logic [7:0] idx);
    is_char_idx = (idx >= `CCR_IDX_BLUE_ALT_LOW) && (idx <= `CCR_IDX_ALT_Y_HIGH);
  endfunction

  // True for any decoded register
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = is_char_idx(idx) || (idx <= `CCR_IDX_LOAD_ALT);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [`CCR_DAT_W-1:0] lane_merge(
    input logic [`CCR_DAT_W-1:0] old_word,
    input logic [`CCR_DAT_W-1:0] new_word,
    input logic [`CCR_SEL_W-1:0] sel);
    logic [`CCR_DAT_W-1:0] merged;
    merged = old_word;
    for (int i = 0; i < `CCR_SEL_W; i++)
    begin
      if (sel[i])
      begin
        merged[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    lane_merge = merged;
  endfunction

  ccr_access_type acc;
  logic [7:0] req_idx;
  logic req_unmapped;
  logic [`CCR_DAT_W-1:0] rd_word;

  logic alt_used_ff;
  logic ro_write_ff;
  logic [7:0] last_cmd_ff;
  logic [7:0] rd_count_ff;
  logic [`CCR_DAT_W-1:0] load_blue_ff;
  logic [`CCR_DAT_W-1:0] load_alt_ff;
  ccr_coord_type blue_out_ff;
  ccr_coord_type alt_out_ff;

  logic wr_ctrl;
  logic wr_status;
  logic wr_load_blue;
  logic wr_load_alt;
  logic wr_char;
  logic rd_char;
  logic soft_clear;
  logic commit;
  logic [`CCR_DAT_W-1:0] ctrl_word;
  logic [`CCR_DAT_W-1:0] status_word;
  logic [`CCR_COORD_W-1:0] coord_load [`CCR_COORD_NUM];
  logic [`CCR_COORD_W-1:0] coord_val [`CCR_COORD_NUM];
  logic [`CCR_COORD_NUM-1:0] coord_en;
  logic [7:0] low_bits_byte;

  // Address decode of the request now on the bus
  assign req_idx = WB_REQ.adr[`CCR_ADR_W-1:2];
  assign req_unmapped = ~is_mapped(req_idx);

  // Handshake and answer timing live in the slave
  ccr_wb_slave u_slave
  (
    .clk(MCLK),
    .rst(RESET),
    .req(WB_REQ),
    .rd_word(rd_word),
    .unmapped(req_unmapped),
    .rsp(WB_RSP),
    .access(acc)
  );

  // Write strobes per register
  assign wr_ctrl = acc.wr && (acc.idx == `CCR_IDX_CTRL);
  assign wr_status = acc.wr && (acc.idx == `CCR_IDX_STATUS);
  assign wr_load_blue = acc.wr && (acc.idx == `CCR_IDX_LOAD_BLUE);
  assign wr_load_alt = acc.wr && (acc.idx == `CCR_IDX_LOAD_ALT);
  assign wr_char = acc.wr && is_char_idx(acc.idx);
  assign rd_char = acc.rd && is_char_idx(acc.idx);

  // Software reset from the command decoder or the control register
  assign soft_clear = SW_RESET_CMD | (wr_ctrl & acc.sel[0] & acc.dat[`CCR_CTRL_SW_RESET]);
  assign commit = wr_ctrl & acc.sel[0] & acc.dat[`CCR_CTRL_COMMIT];

  // Alternate-used flag; cleared by either reset so nothing stale reads back
  always_ff @(posedge MCLK)
  begin
    if (RESET || soft_clear)
    begin
      alt_used_ff <= 1'b0;
    end
    else if (wr_ctrl && acc.sel[0])
    begin
      alt_used_ff <= acc.dat[`CCR_CTRL_ALT_USED];
    end
  end

  // Staging words; a commit copies them into the coordinates at once
  always_ff @(posedge MCLK)
  begin
    if (RESET || soft_clear)
    begin
      load_blue_ff <= `CCR_RESET_WORD;
      load_alt_ff <= `CCR_RESET_WORD;
    end
    else
    begin
      if (wr_load_blue)
      begin
        load_blue_ff <= lane_merge(load_blue_ff, acc.dat, acc.sel);
      end
      if (wr_load_alt)
      begin
        load_alt_ff <= lane_merge(load_alt_ff, acc.dat, acc.sel);
      end
    end
  end

  // Coordinate sources in order blue x, blue y, alternate x, alternate y
  assign coord_load[0] = load_blue_ff[`CCR_LOAD_X_LSB +: `CCR_COORD_W];
  assign coord_load[1] = load_blue_ff[`CCR_LOAD_Y_LSB +: `CCR_COORD_W];
  assign coord_load[2] = load_alt_ff[`CCR_LOAD_X_LSB +: `CCR_COORD_W];
  assign coord_load[3] = load_alt_ff[`CCR_LOAD_Y_LSB +: `CCR_COORD_W];

  // Blue is always in use; alternate only when software says so
  assign coord_en = {alt_used_ff, alt_used_ff, 1'b1, 1'b1};

  // Four coordinate stores; writes to read codes never reach them
  generate
    for (genvar g = 0; g < `CCR_COORD_NUM; g++)
    begin : g_coord
      ccr_coord_reg u_coord
      (
        .clk(MCLK),
        .rst(RESET),
        .clear(soft_clear),
        .load(commit),
        .load_val(coord_load[g]),
        .enable(coord_en[g]),
        .value(coord_val[g])
      );
    end
  endgenerate

  // Packed low pairs: blue x, blue y, alternate x, alternate y from the top
  assign low_bits_byte = {coord_val[0][1:0], coord_val[1][1:0],
                          coord_val[2][1:0], coord_val[3][1:0]};

  // Control word reads back the flag only; action bits are self-clearing
  assign ctrl_word = {{(`CCR_DAT_W-1){1'b0}}, alt_used_ff};

  // Status word shows power state, flags and read activity
  assign status_word = {8'h00, rd_count_ff, last_cmd_ff, 4'h0, ro_write_ff, alt_used_ff, POWER_STATE};

  // Read selection; no power state gates the characteristic reads
  always_comb
  begin
    case (req_idx)
      `CCR_IDX_CTRL: rd_word = ctrl_word;
      `CCR_IDX_STATUS: rd_word = status_word;
      `CCR_IDX_LOAD_BLUE: rd_word = load_blue_ff;
      `CCR_IDX_LOAD_ALT: rd_word = load_alt_ff;
      `CCR_IDX_BLUE_ALT_LOW: rd_word = {24'h000000, low_bits_byte};
      `CCR_IDX_BLUE_X_HIGH: rd_word = {24'h000000, coord_val[0][9:2]};
      `CCR_IDX_BLUE_Y_HIGH: rd_word = {24'h000000, coord_val[1][9:2]};
      `CCR_IDX_ALT_X_HIGH: rd_word = {24'h000000, coord_val[2][9:2]};
      `CCR_IDX_ALT_Y_HIGH: rd_word = {24'h000000, coord_val[3][9:2]};
      default: rd_word = `CCR_RESET_WORD;
    endcase
  end

  // Sticky flag for a write to a read code; a new attempt beats the clear
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ro_write_ff <= 1'b0;
    end
    else if (wr_char)
    begin
      ro_write_ff <= 1'b1;
    end
    else if (wr_status && acc.sel[0] && acc.dat[`CCR_STAT_RO_WRITE])
    begin
      ro_write_ff <= 1'b0;
    end
  end

  // Read activity: last code read and a wrapping count, kept across soft reset
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      last_cmd_ff <= `CCR_RESET_BYTE;
      rd_count_ff <= `CCR_RESET_BYTE;
    end
    else if (rd_char)
    begin
      last_cmd_ff <= acc.idx;
      rd_count_ff <= rd_count_ff + 8'h01;
    end
  end

  // Registered copies for the rest of the chip
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      blue_out_ff <= '0;
      alt_out_ff <= '0;
    end
    else
    begin
      blue_out_ff <= {coord_val[0], coord_val[1]};
      alt_out_ff <= {coord_val[2], coord_val[3]};
    end
  end

  assign BLUE_COORD = blue_out_ff;
  assign ALT_COORD = alt_out_ff;
  assign ALT_USED = alt_used_ff;

endmodule // ccr_readback_top

// ### design/ccr_wb_slave.sv
// Classic Wishbone slave handshake with registered answer
`timescale 1ns/100ps
`include "ccr_map.svh"

module ccr_wb_slave
(
  input logic clk, // System clock
  input logic rst, // Synchronous reset, active high
  input ccr_pkg::ccr_wb_req_type req, // Request from the master
  input logic [`CCR_DAT_W-1:0] rd_word, // Read word for the current address
  input logic unmapped, // Current address decodes to nothing
  output ccr_pkg::ccr_wb_rsp_type rsp, // Answer to the master
  output ccr_pkg::ccr_access_type access // One-cycle pulse of an accepted access
);
  import ccr_pkg::*;

  ccr_state_type state_ff;
  ccr_state_type nxt_state;
  logic ack_ff;
  logic err_ff;
  logic [`CCR_DAT_W-1:0] dat_ff;
  logic start;

  // A request is taken only from idle, so a held strobe is answered again every second cycle
  assign start = req.cyc & req.stb & (state_ff == CCR_ST_IDLE);

  // Answer lasts one cycle, then the slave returns to idle without waiting for the master to release
  always_comb
  begin
    case (state_ff)
      CCR_ST_IDLE: nxt_state = start ? CCR_ST_ANSWER : CCR_ST_IDLE;
      CCR_ST_ANSWER: nxt_state = CCR_ST_IDLE;
      default: nxt_state = CCR_ST_IDLE;
    endcase
  end

  // Access pulse, taken in the same cycle as the strobe is seen
  assign access.wr = start & req.we & ~unmapped;
  assign access.rd = start & ~req.we & ~unmapped;
  assign access.idx = req.adr[`CCR_ADR_W-1:2];
  assign access.sel = req.sel;
  assign access.dat = req.dat;

  // Answer registers; read data is zero on writes and errors
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= CCR_ST_IDLE;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      dat_ff <= `CCR_RESET_WORD;
    end
    else
    begin
      state_ff <= nxt_state;
      ack_ff <= start & ~unmapped;
      err_ff <= start & unmapped;
      dat_ff <= (start & ~req.we & ~unmapped) ? rd_word : `CCR_RESET_WORD;
    end
  end

  assign rsp.ack = ack_ff;
  assign rsp.err = err_ff;
  assign rsp.dat = dat_ff;

endmodule // ccr_wb_slave

// ### include/ccr_map.svh
// Register indices, field positions, bus widths and reset values of the readback block
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// Register indices; the byte address is four times the index
`define CCR_IDX_CTRL 8'h00
`define CCR_IDX_STATUS 8'h01
`define CCR_IDX_LOAD_BLUE 8'h02
`define CCR_IDX_LOAD_ALT 8'h03
`define CCR_IDX_BLUE_ALT_LOW 8'h7a
`define CCR_IDX_BLUE_X_HIGH 8'h7b
`define CCR_IDX_BLUE_Y_HIGH 8'h7c
`define CCR_IDX_ALT_X_HIGH 8'h7d
`define CCR_IDX_ALT_Y_HIGH 8'h7e

// Bus widths
`define CCR_ADR_W 10
`define CCR_DAT_W 32
`define CCR_SEL_W 4

// Coordinate layout
`define CCR_COORD_W 10
`define CCR_COORD_NUM 4
`define CCR_LOAD_X_LSB 0
`define CCR_LOAD_Y_LSB 16

// Control register fields
`define CCR_CTRL_ALT_USED 0
`define CCR_CTRL_SW_RESET 1
`define CCR_CTRL_COMMIT 2

// Status register fields
`define CCR_STAT_PWR_LSB 0
`define CCR_STAT_ALT_USED 2
`define CCR_STAT_RO_WRITE 3
`define CCR_STAT_LAST_LSB 8
`define CCR_STAT_COUNT_LSB 16

// Reset values
`define CCR_RESET_BYTE 8'h00
`define CCR_RESET_COORD 10'h000
`define CCR_RESET_WORD 32'h0000_0000

`endif

// ### include/ccr_pkg.sv
// Types shared by the readback block and its bus slave
`include "ccr_map.svh"

package ccr_pkg;

  // Power state of the display, reported only; reads are never gated by it
  typedef enum logic [1:0]
  {
    CCR_PWR_NORMAL = 2'b00,
    CCR_PWR_IDLE = 2'b01,
    CCR_PWR_SLEEP = 2'b10,
    CCR_PWR_RSVD = 2'b11
  } ccr_power_type;

  // Bus slave handshake states
  typedef enum logic [0:0]
  {
    CCR_ST_IDLE = 1'b0,
    CCR_ST_ANSWER = 1'b1
  } ccr_state_type;

  // One coordinate pair
  typedef struct packed
  {
    logic [`CCR_COORD_W-1:0] x;
    logic [`CCR_COORD_W-1:0] y;
  } ccr_coord_type;

  // Classic Wishbone request from the master
  typedef struct packed
  {
    logic cyc;
    logic stb;
    logic we;
    logic [`CCR_ADR_W-1:0] adr;
    logic [`CCR_SEL_W-1:0] sel;
    logic [`CCR_DAT_W-1:0] dat;
  } ccr_wb_req_type;

  // Classic Wishbone answer to the master
  typedef struct packed
  {
    logic ack;
    logic err;
    logic [`CCR_DAT_W-1:0] dat;
  } ccr_wb_rsp_type;

  // One accepted access, valid for a single cycle
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [`CCR_SEL_W-1:0] sel;
    logic [`CCR_DAT_W-1:0] dat;
  } ccr_access_type;

endpackage

// ### verification/ccr_host_model.sv
// Host controller model: one classic Wishbone cycle per command
`timescale 1ns/100ps

module ccr_host_model
(
  input logic clk, // Clock
  output ccr_pkg::ccr_wb_req_type req, // Request
  input ccr_pkg::ccr_wb_rsp_type rsp // Answer
);
  initial req = '0;
  // One command, held until answered; released lines show inverted values, not stale ones
  task automatic xfer(input logic we, input logic [9:0] adr, input logic [31:0] dat);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do
      @(posedge clk);
    while ((rsp.ack | rsp.err) !== 1'b1);
    req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~dat};
  endtask
endmodule // ccr_host_model

// ### verification/ccr_readback_assertions.sv
// Port checks of the readback block, bound to its top
`timescale 1ns/100ps

module ccr_readback_assertions
(
  input logic MCLK, // Clock
  input logic RESET, // Reset
  input ccr_pkg::ccr_wb_req_type WB_REQ, // Request
  input ccr_pkg::ccr_wb_rsp_type WB_RSP, // Answer
  input logic SW_RESET_CMD, // Soft reset
  input ccr_pkg::ccr_power_type POWER_STATE, // Power
  input ccr_pkg::ccr_coord_type BLUE_COORD, // Blue
  input ccr_pkg::ccr_coord_type ALT_COORD, // Alternate
  input logic ALT_USED // Alternate on
);
  import ccr_pkg::*;
  // Request is held until its answer, so the index is still valid at the ack edge
  wire req_on = WB_REQ.cyc && WB_REQ.stb;
  wire [7:0] ri = (req_on && !WB_REQ.we) ? WB_REQ.adr[9:2] : 8'hff;
  wire code = ri >= 8'h7a && ri <= 8'h7e;
  wire ra = WB_RSP.ack && !WB_REQ.we;
  wire [7:0] d = WB_RSP.dat[7:0];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_ack_single: assert property (WB_RSP.ack |=> !WB_RSP.ack) else $error("ack long");
  a_read_answered: assert property ($rose(req_on) && code |=> WB_RSP.ack && !WB_RSP.err) else $error("no ack");
  a_one_byte: assert property (ra && code |-> WB_RSP.dat[31:8] == 24'h0) else $error("wide");
  a_low_pack: assert property (ra && ri == 8'h7a |-> d == {BLUE_COORD.x[1:0], BLUE_COORD.y[1:0],
    ALT_COORD.x[1:0], ALT_COORD.y[1:0]}) else $error("low pack");
  a_low_alt_off: assert property (ra && ri == 8'h7a && !ALT_USED |-> d[3:0] == 4'h0) else $error("alt low");
  a_blue_x: assert property (ra && ri == 8'h7b |-> d == BLUE_COORD.x[9:2]) else $error("bx");
  a_blue_y: assert property (ra && ri == 8'h7c |-> d == BLUE_COORD.y[9:2]) else $error("by");
  a_alt_x: assert property (ra && ri == 8'h7d |-> d == (ALT_USED ? ALT_COORD.x[9:2] : 8'h00)) else $error("ax");
  a_alt_y: assert property (ra && ri == 8'h7e |-> d == (ALT_USED ? ALT_COORD.y[9:2] : 8'h00)) else $error("ay");
  a_hw_reset_zero: assert property ($fell(RESET) |-> BLUE_COORD == '0 && ALT_COORD == '0 && !ALT_USED)
    else $error("hw reset");
  a_soft_clear: assert property (SW_RESET_CMD |=> !ALT_USED ##1 BLUE_COORD == '0 && ALT_COORD == '0)
    else $error("sw reset");
  c_low_alt: cover property (ra && ri == 8'h7a && ALT_USED);
  c_sleep_read: cover property (ra && code && POWER_STATE == CCR_PWR_SLEEP);
  c_unmapped: cover property (WB_RSP.err);
endmodule // ccr_readback_assertions

bind ccr_readback_top ccr_readback_assertions i_ccr_readback_assertions (.MCLK(MCLK), .RESET(RESET),
  .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .SW_RESET_CMD(SW_RESET_CMD), .POWER_STATE(POWER_STATE),
  .BLUE_COORD(BLUE_COORD), .ALT_COORD(ALT_COORD), .ALT_USED(ALT_USED));

// ### verification/tb_ccr_readback_top.sv
// Self-checking bench for the readback block
`timescale 1ns/100ps

module tb_ccr_readback_top;
  import ccr_pkg::*;
  logic MCLK;
  logic RESET;
  logic SW_RESET_CMD;
  ccr_power_type POWER_STATE;
  ccr_wb_req_type WB_REQ;
  ccr_wb_rsp_type WB_RSP;
  ccr_coord_type BLUE_COORD;
  ccr_coord_type ALT_COORD;
  logic ALT_USED;
  logic [32:0] exp_q[$];
  logic [32:0] got;
  logic [9:0] bx, by, ax, ay;
  int errors;
  int n_tests;

  ccr_readback_top i_ccr_readback_top (.MCLK(MCLK), .RESET(RESET), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP),
    .SW_RESET_CMD(SW_RESET_CMD), .POWER_STATE(POWER_STATE), .BLUE_COORD(BLUE_COORD),
    .ALT_COORD(ALT_COORD), .ALT_USED(ALT_USED));
  ccr_host_model i_ccr_host_model (.clk(MCLK), .req(WB_REQ), .rsp(WB_RSP));

  // 50 MHz clock
  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  task automatic summarize();
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Reads note their expected {err, data} before the cycle starts
  task automatic rd(input logic [9:0] adr, input logic [32:0] e);
    exp_q.push_back(e);
    i_ccr_host_model.xfer(1'b0, adr, 32'h0);
  endtask

  task automatic wr(input logic [9:0] adr, input logic [31:0] dat);
    i_ccr_host_model.xfer(1'b1, adr, dat);
  endtask

  // All five read codes, cycling through normal, idle and sleep
  task automatic rd_all(input logic [9:0] px, py, qx, qy);
    logic [7:0] e [5];
    e = '{{px[1:0], py[1:0], qx[1:0], qy[1:0]}, px[9:2], py[9:2], qx[9:2], qy[9:2]};
    for (int i = 0; i < 5; i++)
    begin
      POWER_STATE <= ccr_power_type'(2'(i % 3));
      rd(10'h1e8 + 10'(4 * i), {25'h0, e[i]});
    end
  endtask

  // Staged coordinates, then commit with the given control bits
  task automatic load(input logic [31:0] ctrl);
    wr(10'h008, {6'h0, by, 6'h0, bx});
    wr(10'h00c, {6'h0, ay, 6'h0, ax});
    wr(10'h000, ctrl);
  endtask

  // Registered coordinate copies and the flag, looked at while idle
  task automatic chk_out(input logic [19:0] eb, input logic [19:0] ea, input logic eu);
    @(posedge MCLK);
    n_tests++;
    if ({BLUE_COORD, ALT_COORD, ALT_USED} !== {eb, ea, eu})
    begin
      errors++;
      $display("BAD coord outputs exp %h got %h", {eb, ea, eu}, {BLUE_COORD, ALT_COORD, ALT_USED});
    end
  endtask

  // Result watcher: every read answer takes the oldest note
  always @(posedge MCLK)
  begin
    if (((WB_RSP.ack | WB_RSP.err) & ~WB_REQ.we) === 1'b1)
    begin
      got = exp_q.pop_front();
      n_tests++;
      if ({WB_RSP.err, WB_RSP.dat} !== got)
      begin
        errors++;
        $display("BAD read answer exp %h got %h", got, {WB_RSP.err, WB_RSP.dat});
      end
    end
  end

  // Watchdog well beyond the fewer than two hundred cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge MCLK);
    errors++;
    summarize();
  end

  initial
  begin
    RESET = 1'b1;
    SW_RESET_CMD = 1'b0;
    POWER_STATE = CCR_PWR_NORMAL;
    errors = 0;
    n_tests = 0;
    void'($urandom(22107));
    {bx, by, ax, ay} = {10'($urandom), 10'($urandom), 10'($urandom), 10'($urandom)};
    repeat (16) @(posedge MCLK);
    RESET <= 1'b0;
    rd_all(10'h0, 10'h0, 10'h0, 10'h0);
    load(32'h5);
    rd_all(bx, by, ax, ay);
    chk_out({bx, by}, {ax, ay}, 1'b1);
    wr(10'h1ec, 32'($urandom));
    wr(10'h1e8, 32'hff);
    rd_all(bx, by, ax, ay);
    wr(10'h000, 32'h4);
    rd_all(bx, by, 10'h0, 10'h0);
    chk_out({bx, by}, 20'h00000, 1'b0);
    wr(10'h000, 32'h1);
    rd_all(bx, by, ax, ay);
    rd(10'h200, {1'b1, 32'h0});
    @(posedge MCLK) SW_RESET_CMD <= 1'b1;
    @(posedge MCLK) SW_RESET_CMD <= 1'b0;
    rd_all(10'h0, 10'h0, 10'h0, 10'h0);
    chk_out(20'h00000, 20'h00000, 1'b0);
    load(32'h5);
    @(posedge MCLK) RESET <= 1'b1;
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    rd_all(10'h0, 10'h0, 10'h0, 10'h0);
    chk_out(20'h00000, 20'h00000, 1'b0);
    summarize();
  end
endmodule // tb_ccr_readback_top
